// ===== pif_defs.svh
// Purpose: register offsets, bit positions and reset values of the peripheral flag block
// Assumes: 8-bit register port, one core clock
// Notes: included by both ends
`ifndef PIF_DEFS_SVH
`define PIF_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PIF_ADDR_IRQ_CTRL 8'h0b
`define PIF_ADDR_FLAGS_A 8'h0c
`define PIF_ADDR_FLAGS_B 8'h0d
`define PIF_ADDR_ENABLES_A 8'h8c
`define PIF_ADDR_ENABLES_B 8'h8d
`define PIF_ADDR_CAUSE 8'h8e

// ----------------------------------------
// bit positions
// ----------------------------------------
`define PIF_BIT_CONV_DONE 6
`define PIF_BIT_SERIAL 3
`define PIF_BIT_CAPCMP 2
`define PIF_BIT_PERIOD 1
`define PIF_BIT_TIMER_A_OVF 0
`define PIF_BIT_NV_DONE 4
`define PIF_BIT_COLLISION 3
`define PIF_BIT_POWER_ON 1
`define PIF_BIT_BROWNOUT 0
`define PIF_BIT_GLOBAL_EN 7
`define PIF_BIT_GROUP_EN 6

// ----------------------------------------
// masks and reset values
// ----------------------------------------
`define PIF_A_IMPL 8'h4f
`define PIF_B_IMPL 8'h18
`define PIF_B_STORE 8'h59
`define PIF_CAUSE_IMPL 8'h03
`define PIF_CTRL_IMPL 8'hc0
`define PIF_RST_FLAGS 8'h00
`define PIF_RST_ENABLES 8'h00
`define PIF_RST_CTRL 8'h00
`define PIF_RST_CAUSE 8'h01

`endif

// ===== pif_pkg.sv
// Purpose: shared types of the peripheral flag block
// Assumes: nothing
// Notes: mode encodings driven by the serial port and capture/compare unit
package pif_pkg;
  typedef enum logic [1:0] {
    PIF_SP_SPI = 2'b00,
    PIF_SP_I2C_SLAVE = 2'b01,
    PIF_SP_I2C_MASTER = 2'b10,
    PIF_SP_OFF = 2'b11
  } pif_sp_mode_t;

  typedef enum logic [1:0] {
    PIF_CC_CAPTURE = 2'b00,
    PIF_CC_COMPARE = 2'b01,
    PIF_CC_PWM = 2'b10,
    PIF_CC_OFF = 2'b11
  } pif_cc_mode_t;
endpackage

// ===== pif_link_if.sv
// Purpose: joins the controller end to the flag register end
// Assumes: both ends on core_clk
// Notes: read data returns one cycle after the read strobe
`timescale 1ns/1ps
interface pif_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [7:0] clr_a;
  logic [7:0] clr_b;
  logic serial_clr;
  logic irq;

  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    input clr_a,
    input clr_b,
    input serial_clr,
    output rdata,
    output irq
  );

  modport ctl (
    output addr,
    output wdata,
    output wr,
    output rd,
    output clr_a,
    output clr_b,
    output serial_clr,
    input rdata,
    input irq
  );
endinterface

// ===== pif_flags_dev.sv
// Purpose: peripheral flag, enable and reset-cause registers with combined request
// Assumes: peripheral event inputs are one-cycle pulses on core_clk
// Notes: hardware set wins over any clear in the same cycle
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "pif_defs.svh"

// Behaviour
// [R1] flags set regardless of any enable
// [R2] software clears flag before enabling source
// [R3] conversion done sets bit 6, sticky
// [R4] reserved bits of first flags written zero
// [R5] serial flag on every byte transfer
// [R6] master sequence completion sets serial flag
// [R7] idle master sees start/stop, sets flag
// [R8] service clears serial flag before return; the controller pulses serial_clr the cycle after isr_return
// [R9] capture or compare event sets bit 2
// [R10] period match sets bit 1, software clears
// [R11] timer overflow sets bit 0, software clears
// [R12] second enables: bit 4 and 3
// [R13] nonvolatile write done sets bit 4
// [R14] master bus collision sets bit 3
// [R15] second registers unimplemented bits read zero
// [R16] power-on reset clears power-on indicator
// [R17] brown-out reset clears brown-out indicator
// [R18] brown-out indicator meaningless when detection off
// [R19] reset-cause bits 7-2 read zero
// [R20] group enable gates every peripheral request
// [R21] first enables mirror first flags positions
// [R22] request when flag and enable both set
// [R23] hardware set beats same-cycle clear
module pif_flags_dev
  import pif_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  pif_link_if.dev link,
  input wire logic conv_done,
  input wire pif_sp_mode_t sp_mode,
  input wire logic sp_xfer_done,
  input wire logic sp_seq_done,
  input wire logic sp_bus_start_stop,
  input wire logic sp_idle,
  input wire logic sp_collision,
  input wire pif_cc_mode_t cc_mode,
  input wire logic cc_capture,
  input wire logic cc_match,
  input wire logic period_match,
  input wire logic timer_a_overflow,
  input wire logic nv_write_done,
  input wire logic por_event,
  input wire logic bor_event,
  input wire logic brownout_detect_enable,
  output logic periph_irq
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] flags_a_reg;
  logic [7:0] flags_a_next;
  logic [7:0] flags_b_reg;
  logic [7:0] flags_b_next;
  logic [7:0] enables_a_reg;
  logic [7:0] enables_b_reg;
  logic [7:0] irq_ctrl_reg;
  logic [7:0] cause_reg;
  logic [7:0] cause_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] hw_clr_a;
  logic sp_master;
  logic wr_flags_a;
  logic wr_flags_b;
  logic wr_cause;

  // ----------------------------------------
  // hardware set events
  // ----------------------------------------
  assign sp_master = (sp_mode == PIF_SP_I2C_MASTER);

  always_comb begin
    set_a = 8'h00;
    set_b = 8'h00;
    set_a[`PIF_BIT_CONV_DONE] = conv_done; // R3
    set_a[`PIF_BIT_SERIAL] = (sp_xfer_done && sp_mode != PIF_SP_OFF) // R5
      || (sp_master && sp_seq_done) // R6
      || (sp_master && sp_idle && sp_bus_start_stop); // R7
    set_a[`PIF_BIT_CAPCMP] = (cc_mode == PIF_CC_CAPTURE && cc_capture)
      || (cc_mode == PIF_CC_COMPARE && cc_match); // R9
    set_a[`PIF_BIT_PERIOD] = period_match; // R10
    set_a[`PIF_BIT_TIMER_A_OVF] = timer_a_overflow; // R11
    set_b[`PIF_BIT_NV_DONE] = nv_write_done; // R13
    set_b[`PIF_BIT_COLLISION] = sp_master && sp_collision; // R14
  end

  assign wr_flags_a = link.wr && link.addr == `PIF_ADDR_FLAGS_A;
  assign wr_flags_b = link.wr && link.addr == `PIF_ADDR_FLAGS_B;
  assign wr_cause = link.wr && link.addr == `PIF_ADDR_CAUSE;

  // ----------------------------------------
  // flag update, set wins
  // ----------------------------------------
  always_comb begin
    hw_clr_a = link.clr_a;
    hw_clr_a[`PIF_BIT_SERIAL] = link.clr_a[`PIF_BIT_SERIAL] | link.serial_clr; // R8
    if (wr_flags_a) begin
      flags_a_next = link.wdata & `PIF_A_IMPL;
    end else begin
      flags_a_next = flags_a_reg & ~hw_clr_a; // R2
    end
    flags_a_next = flags_a_next | set_a; // R1 R23
    if (wr_flags_b) begin
      flags_b_next = link.wdata & `PIF_B_STORE;
    end else begin
      flags_b_next = flags_b_reg & ~link.clr_b;
    end
    flags_b_next = flags_b_next | set_b; // R1 R23
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_a_reg <= `PIF_RST_FLAGS;
      flags_b_reg <= `PIF_RST_FLAGS;
    end else begin
      flags_a_reg <= flags_a_next;
      flags_b_reg <= flags_b_next;
    end
  end

  // ----------------------------------------
  // enables and core control
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enables_a_reg <= `PIF_RST_ENABLES;
      enables_b_reg <= `PIF_RST_ENABLES;
      irq_ctrl_reg <= `PIF_RST_CTRL;
    end else if (link.wr) begin
      if (link.addr == `PIF_ADDR_ENABLES_A) begin
        enables_a_reg <= link.wdata; // R21
      end
      if (link.addr == `PIF_ADDR_ENABLES_B) begin
        enables_b_reg <= link.wdata & `PIF_B_STORE; // R12
      end
      if (link.addr == `PIF_ADDR_IRQ_CTRL) begin
        irq_ctrl_reg <= link.wdata & `PIF_CTRL_IMPL;
      end
    end
  end

  // ----------------------------------------
  // reset cause
  // ----------------------------------------
  always_comb begin
    cause_next = cause_reg;
    if (wr_cause) begin
      cause_next = link.wdata & `PIF_CAUSE_IMPL;
    end
    if (por_event) begin
      cause_next[`PIF_BIT_POWER_ON] = 1'b0; // R16
    end
    if (bor_event && brownout_detect_enable) begin
      cause_next[`PIF_BIT_BROWNOUT] = 1'b0; // R17 R18
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= `PIF_RST_CAUSE;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // ----------------------------------------
  // combined request
  // ----------------------------------------
  always_comb begin
    irq_next = irq_ctrl_reg[`PIF_BIT_GLOBAL_EN] && irq_ctrl_reg[`PIF_BIT_GROUP_EN] // R20
      && (|(flags_a_reg & enables_a_reg & `PIF_A_IMPL)
      || |(flags_b_reg & enables_b_reg & `PIF_B_IMPL)); // R22
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (link.rd) begin
      case (link.addr)
        `PIF_ADDR_FLAGS_A: begin
          rdata_next = flags_a_reg;
        end
        `PIF_ADDR_FLAGS_B: begin
          rdata_next = flags_b_reg & `PIF_B_STORE; // R15
        end
        `PIF_ADDR_ENABLES_A: begin
          rdata_next = enables_a_reg;
        end
        `PIF_ADDR_ENABLES_B: begin
          rdata_next = enables_b_reg & `PIF_B_STORE; // R15
        end
        `PIF_ADDR_IRQ_CTRL: begin
          rdata_next = irq_ctrl_reg;
        end
        `PIF_ADDR_CAUSE: begin
          rdata_next = cause_reg & `PIF_CAUSE_IMPL; // R19
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign link.rdata = rdata_reg;
  assign link.irq = irq_reg;
  assign periph_irq = irq_reg;

endmodule

// ===== pif_flags_ctl.sv
// Purpose: software-side controller of the peripheral flag registers
// Assumes: one access per cycle from the user port
// Notes: forwards accesses, keeps reserved bits zero, clears stale flags on enable
`timescale 1ns/1ps
`include "pif_defs.svh"
module pif_flags_ctl
  import pif_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  pif_link_if.ctl link,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic isr_return,
  output logic [7:0] cmd_rdata,
  output logic irq_out
);

  // ----------------------------------------
  // shadows of enables written
  // ----------------------------------------
  logic [7:0] en_a_shadow_reg;
  logic [7:0] en_b_shadow_reg;
  logic serial_clr_reg;
  logic irq_reg;
  logic [7:0] wdata_safe;

  always_comb begin
    wdata_safe = cmd_wdata;
    if (cmd_addr == `PIF_ADDR_FLAGS_A || cmd_addr == `PIF_ADDR_ENABLES_A) begin
      wdata_safe = cmd_wdata & `PIF_A_IMPL; // R4
    end else if (cmd_addr == `PIF_ADDR_FLAGS_B || cmd_addr == `PIF_ADDR_ENABLES_B) begin
      wdata_safe = cmd_wdata & `PIF_B_IMPL; // R15
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_a_shadow_reg <= `PIF_RST_ENABLES;
      en_b_shadow_reg <= `PIF_RST_ENABLES;
    end else if (cmd_wr) begin
      if (cmd_addr == `PIF_ADDR_ENABLES_A) begin
        en_a_shadow_reg <= wdata_safe;
      end
      if (cmd_addr == `PIF_ADDR_ENABLES_B) begin
        en_b_shadow_reg <= wdata_safe;
      end
    end
  end

  // ----------------------------------------
  // forwarding
  // ----------------------------------------
  assign link.addr = cmd_addr;
  assign link.wdata = wdata_safe;
  assign link.wr = cmd_wr;
  assign link.rd = cmd_rd;
  assign link.clr_a = (cmd_wr && cmd_addr == `PIF_ADDR_ENABLES_A)
    ? (wdata_safe & ~en_a_shadow_reg) : 8'h00; // R2
  assign link.clr_b = (cmd_wr && cmd_addr == `PIF_ADDR_ENABLES_B)
    ? (wdata_safe & ~en_b_shadow_reg) : 8'h00; // R2

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_clr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      serial_clr_reg <= isr_return; // R8
      irq_reg <= link.irq;
    end
  end

  assign link.serial_clr = serial_clr_reg;
  assign cmd_rdata = link.rdata;
  assign irq_out = irq_reg;

endmodule

// ===== pif_link_checker.sv
// Purpose: assertions on the link between controller and flag registers
// Assumes: one core_clk domain, async active-low reset
// Notes: sees only the interface signals
`timescale 1ns/1ps
module pif_link_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] clr_a,
  input wire logic [7:0] clr_b,
  input wire logic serial_clr,
  input wire logic irq
);
  logic [1:0] gate_reg;
  default clocking chk_cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // shadow of the global and group enables
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_reg <= 2'h0;
    end else if (wr && addr == 8'h0b) begin
      gate_reg <= wdata[7:6];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_cause_upper_zero: assert property ($past(rd) && $past(addr) == 8'h8e |-> rdata[7:2] == 6'h00)
    else $error("reset cause upper bits set");
  a_b_unused_zero: assert property ($past(rd) && ($past(addr) == 8'h0d || $past(addr) == 8'h8d)
    |-> rdata[7] == 1'b0 && rdata[5] == 1'b0 && rdata[2:1] == 2'h0)
    else $error("second register unused bit set");
  a_a_reserved_wr: assert property (wr && (addr == 8'h0c || addr == 8'h8c)
    |-> wdata[7] == 1'b0 && wdata[5:4] == 2'h0)
    else $error("first register reserved bit written");
  a_b_reserved_wr: assert property (wr && (addr == 8'h0d || addr == 8'h8d)
    |-> wdata[6] == 1'b0 && wdata[0] == 1'b0)
    else $error("second register reserved bit written");
  a_irq_gated: assert property (irq |-> $past(gate_reg) == 2'h3)
    else $error("request without global and group enable");
  a_clr_a_stale: assert property (clr_a != 8'h00
    |-> wr && addr == 8'h8c && (clr_a & ~wdata) == 8'h00)
    else $error("first clear mask outside enable write");
  a_clr_b_stale: assert property (clr_b != 8'h00
    |-> wr && addr == 8'h8d && (clr_b & ~wdata) == 8'h00)
    else $error("second clear mask outside enable write");
  a_serial_clr_pulse: assert property (serial_clr |=> !serial_clr)
    else $error("serial clear longer than one cycle");
endmodule

// ===== test_peripheral_irq_flags_reset_status.sv
// Purpose: self-checking bench for both ends of the peripheral flag block
// Assumes: 50 MHz core_clk, read data one cycle after the read strobe
// Notes: peripheral events are one-cycle pulses packed in ev
`timescale 1ns/1ps
module test_peripheral_irq_flags_reset_status import pif_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic isr_return = 1'b0;
  logic sp_idle = 1'b1;
  logic brownout_detect_enable = 1'b1;
  logic [11:0] ev = 12'h000;
  pif_sp_mode_t sp_mode = PIF_SP_SPI;
  pif_cc_mode_t cc_mode = PIF_CC_CAPTURE;
  logic [7:0] cmd_rdata;
  logic irq_out;
  logic periph_irq;
  int mismatches = 0;
  int samples_checked = 0;
  logic [35:0] tab [20];
  always #10 core_clk = ~core_clk;
  pif_link_if link ();
  pif_flags_dev u_pif_flags_dev (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .conv_done(ev[0]), .sp_mode(sp_mode), .sp_xfer_done(ev[1]), .sp_seq_done(ev[2]),
    .sp_bus_start_stop(ev[3]), .sp_idle(sp_idle), .sp_collision(ev[4]), .cc_mode(cc_mode),
    .cc_capture(ev[5]), .cc_match(ev[6]), .period_match(ev[7]), .timer_a_overflow(ev[8]),
    .nv_write_done(ev[9]), .por_event(ev[10]), .bor_event(ev[11]),
    .brownout_detect_enable(brownout_detect_enable), .periph_irq(periph_irq));
  pif_flags_ctl u_pif_flags_ctl (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .isr_return(isr_return), .cmd_rdata(cmd_rdata), .irq_out(irq_out));
  pif_link_checker u_pif_link_checker (.core_clk(core_clk), .rst_n(rst_n), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .clr_a(link.clr_a),
    .clr_b(link.clr_b), .serial_clr(link.serial_clr), .irq(link.irq));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge core_clk);
    cmd_rd <= 1'b0;
    #1;
    chk(cmd_rdata, exp);
    @(posedge core_clk);
  endtask
  task automatic fire(input logic [11:0] m);
    ev <= m;
    @(posedge core_clk);
    ev <= 12'h000;
    @(posedge core_clk);
  endtask
  task automatic irq_chk(input logic [7:0] exp);
    repeat (2) @(posedge core_clk);
    #1;
    chk({7'h00, irq_out}, exp);
    chk({7'h00, periph_irq}, exp);
    @(posedge core_clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end
  initial begin
    tab = '{36'h010010c40, 36'h010020c08, 36'h410020c08, 36'h810020c08, 36'hc10020c00,
      36'h810040c08, 36'h010040c00, 36'h810080c08, 36'h800080c00, 36'h010200c04,
      36'h110400c04, 36'h210600c00, 36'h010800c02, 36'h011000c01, 36'h810100d08,
      36'h010100d00, 36'h012000d10, 36'h310600c00, 36'h110200c00, 36'h410040c00};
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd_chk(8'h0c, 8'h00);
    rd_chk(8'h0d, 8'h00);
    rd_chk(8'h8c, 8'h00);
    rd_chk(8'h8d, 8'h00);
    rd_chk(8'h8e, 8'h01);
    rd_chk(8'h0b, 8'h00);
    rd_chk(8'h20, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 20; i++) begin
      sp_mode <= pif_sp_mode_t'(tab[i][35:34]);
      cc_mode <= pif_cc_mode_t'(tab[i][33:32]);
      sp_idle <= tab[i][28];
      @(posedge core_clk);
      fire(tab[i][27:16]);
      rd_chk(tab[i][15:8], tab[i][7:0]);
      wr_reg(tab[i][15:8], 8'h00);
    end
    $display("test event sources done");
    ev <= 12'h100;
    cmd_addr <= 8'h0c;
    cmd_wdata <= 8'h00;
    cmd_wr <= 1'b1;
    @(posedge core_clk);
    ev <= 12'h000;
    cmd_wr <= 1'b0;
    repeat (5) @(posedge core_clk);
    rd_chk(8'h0c, 8'h01);
    wr_reg(8'h0c, 8'hff);
    rd_chk(8'h0c, 8'h4f);
    wr_reg(8'h0d, 8'hff);
    rd_chk(8'h0d, 8'h18);
    wr_reg(8'h8d, 8'hff);
    rd_chk(8'h8d, 8'h18);
    rd_chk(8'h0d, 8'h00);
    wr_reg(8'h8c, 8'h01);
    rd_chk(8'h0c, 8'h4e);
    rd_chk(8'h8c, 8'h01);
    $display("test register access done");
    wr_reg(8'h0b, 8'h80);
    fire(12'h100);
    irq_chk(8'h00);
    wr_reg(8'h0b, 8'hc0);
    irq_chk(8'h01);
    wr_reg(8'h0c, 8'h00);
    irq_chk(8'h00);
    fire(12'h200);
    irq_chk(8'h01);
    wr_reg(8'h0d, 8'h00);
    wr_reg(8'h0b, 8'h00);
    wr_reg(8'h0c, 8'h08);
    isr_return <= 1'b1;
    @(posedge core_clk);
    isr_return <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd_chk(8'h0c, 8'h00);
    $display("test request path done");
    wr_reg(8'h8e, 8'hff);
    rd_chk(8'h8e, 8'h03);
    fire(12'h400);
    rd_chk(8'h8e, 8'h01);
    fire(12'h800);
    rd_chk(8'h8e, 8'h00);
    wr_reg(8'h8e, 8'h03);
    brownout_detect_enable <= 1'b0;
    fire(12'h800);
    rd_chk(8'h8e, 8'h03);
    $display("test reset cause done");
    stop_test();
  end
endmodule
